// ==== wod_pkg.sv ====
// Constants for the wake-up and orientation event block.
// Register offsets, config bit positions, resets and threshold tables.
package wod_pkg;

  // Register offsets (byte addresses on the 8-bit register port)
  localparam logic [7:0] A_FUNC_EN  = 8'h00;
  localparam logic [7:0] A_TAP_CONFIG0_REG = 8'h01;
  localparam logic [7:0] A_CONTROL9_REG    = 8'h02;
  localparam logic [7:0] A_WU_THS   = 8'h03;
  localparam logic [7:0] A_WU_DUR   = 8'h04;
  localparam logic [7:0] A_INACT    = 8'h05;
  localparam logic [7:0] A_OR_THS   = 8'h06;
  localparam logic [7:0] A_ROUTE1   = 8'h07;
  localparam logic [7:0] A_ROUTE2   = 8'h08;
  localparam logic [7:0] A_X_OFS    = 8'h09;
  localparam logic [7:0] A_Y_OFS    = 8'h0A;
  localparam logic [7:0] A_Z_OFS    = 8'h0B;
  localparam logic [7:0] A_WU_SRC   = 8'h0C;
  localparam logic [7:0] A_OR_SRC   = 8'h0D;
  localparam logic [7:0] A_ALL_SRC  = 8'h0E;

  localparam logic [7:0] REG_RESET  = 8'h00;

  // Bit positions
  localparam int B_INT_EN    = 7;  // functions enable
  localparam int B_LIR       = 0;  // tap_config0_reg
  localparam int B_FPS       = 4;
  localparam int B_SET_MASK  = 5;
  localparam int B_LP6D      = 6;
  localparam int B_FAST_SET  = 5;  // control9_reg
  localparam int B_OFS_ON_WU = 6;  // wakeup_threshold_reg
  localparam int B_THS_HI    = 5;
  localparam int B_DUR_HI    = 6;  // wakeup_duration_reg
  localparam int B_DUR_LO    = 5;
  localparam int B_RES_HI    = 6;  // inactivity_duration_reg
  localparam int B_RES_LO    = 4;
  localparam int B_OTH_HI    = 6;  // orientation_threshold_reg
  localparam int B_OTH_LO    = 5;
  localparam int B_FOUR_EN   = 7;
  localparam int B_RT_WU     = 5;  // pin route registers
  localparam int B_RT_OR     = 2;

  // Position offset weight, as a left shift of the 8-bit offset
  localparam int OFS_SHIFT = 3;

  // Wake-up threshold weight per LSB, in data LSBs of 0.5 mg
  localparam logic [7:0] WU_WEIGHT_0 = 8'h0B;
  localparam logic [7:0] WU_WEIGHT_1 = 8'h1F;
  localparam logic [7:0] WU_WEIGHT_2 = 8'h3E;
  localparam logic [7:0] WU_WEIGHT_3 = 8'h7D;  // 62.5 mg
  localparam logic [7:0] WU_WEIGHT_4 = 8'hFA;
  localparam logic [7:0] WU_WEIGHT_X = 8'hFA;

  // Orientation thresholds in data LSBs, independent of full scale
  localparam logic [15:0] OR_THS_0 = 16'h0700;
  localparam logic [15:0] OR_THS_1 = 16'h0600;
  localparam logic [15:0] OR_THS_2 = 16'h03E8;  // 60 degrees
  localparam logic [15:0] OR_THS_3 = 16'h02B0;

  localparam logic [1:0] DUR_MAX = 2'h3;

  function automatic logic [7:0] wu_weight(input logic [2:0] sel);
    case (sel)
      3'h0: wu_weight = WU_WEIGHT_0;
      3'h1: wu_weight = WU_WEIGHT_1;
      3'h2: wu_weight = WU_WEIGHT_2;
      3'h3: wu_weight = WU_WEIGHT_3;
      3'h4: wu_weight = WU_WEIGHT_4;
      default: wu_weight = WU_WEIGHT_X;
    endcase
  endfunction : wu_weight

  function automatic logic [15:0] or_ths(input logic [1:0] sel);
    case (sel)
      2'h0: or_ths = OR_THS_0;
      2'h1: or_ths = OR_THS_1;
      2'h2: or_ths = OR_THS_2;
      default: or_ths = OR_THS_3;
    endcase
  endfunction : or_ths

endpackage : wod_pkg

// ==== wod_detect.sv ====
// Wake-up and six/four orientation event detection with two interrupt pins.
// Assumes filtered axis data, sample strobe and settling flag on CLK_SYS_IN.
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Wake-up uses slope filter when path select is 0, high-pass when 1.
// - Path select and offset bit both set: low-pass data minus position offsets.
// - Sample counts only when magnitude is strictly above the threshold.
// - Threshold is six unsigned bits weighted by a three-bit resolution select.
// - Resolution code 011 weighs the threshold at 62.5 mg per LSB.
// - Event after duration-many extra consecutive exceeding samples; zero fires each one.
// - Pins show wake-up only with interrupts enabled and pin routing set.
// - Per-axis wake-up flags hold their trigger values while latched.
// - Unlatched wake-up drops as soon as data falls below threshold.
// - Latched routed wake-up stays until a source register read.
// - Latching applies only to functions routed to some pin.
// - First slope sample uses zero as previous; spurious event lasts one sample.
// - Fast settle plus mask suppresses all triggers while filters settle.
// - Orientation fires on change between orientations, not while one persists.
// - Orientation needs two samples with exactly one axis above threshold.
// - Each axis has high flag when positive, low flag when negative.
// - Two-bit orientation threshold select, code 10 is 60 degrees, any scale.
// - Orientation low-pass select feeds orientation from the second low-pass.
// - Unlatched orientation event lasts exactly one sample period.
// - Latched orientation clears on source read and rearms for another orientation.
// - Position flags always show current state regardless of latching.
// - Four-orientation enable drops Z axis position detection.
// - Each pin is the OR of all sources routed to it.
module wod_detect
  import wod_pkg::*;
#(
  parameter int DW = 16
) (
  input  wire logic                 CLK_SYS_IN,
  input  wire logic                 NRST_IN,
  input  wire logic                 CE_IN,
  input  wire logic [7:0]           ADDR_IN,
  input  wire logic [7:0]           WDATA_IN,
  input  wire logic                 WR_IN,
  input  wire logic                 RD_IN,
  output logic      [7:0]           RDATA_OUT,
  input  wire logic                 SAMPLE_STB_IN,
  input  wire logic                 SETTLING_IN,
  input  wire logic signed [DW-1:0] ACC_X_IN,
  input  wire logic signed [DW-1:0] ACC_Y_IN,
  input  wire logic signed [DW-1:0] ACC_Z_IN,
  input  wire logic signed [DW-1:0] HPF_X_IN,
  input  wire logic signed [DW-1:0] HPF_Y_IN,
  input  wire logic signed [DW-1:0] HPF_Z_IN,
  input  wire logic signed [DW-1:0] SECOND_LOWPASS_FILTER_X_IN,
  input  wire logic signed [DW-1:0] SECOND_LOWPASS_FILTER_Y_IN,
  input  wire logic signed [DW-1:0] SECOND_LOWPASS_FILTER_Z_IN,
  output logic                      INTERRUPT_PIN_ONE_OUT,
  output logic                      INTERRUPT_PIN_TWO_OUT
);

  localparam int EW = DW + 1;

  logic [7:0] fen_q, tap_q, control9_reg_q, wu_ths_q, wu_dur_q, inact_q, or_ths_q;
  logic [7:0] route1_q, route2_q;
  logic [7:0] ofs_q [3];
  logic [7:0] rdata_q;

  // Register port decode
  wire rd_wu  = RD_IN && (ADDR_IN == A_WU_SRC);
  wire rd_or  = RD_IN && (ADDR_IN == A_OR_SRC);
  wire rd_all = RD_IN && (ADDR_IN == A_ALL_SRC);

  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      fen_q    <= REG_RESET;
      tap_q    <= REG_RESET;
      control9_reg_q  <= REG_RESET;
      wu_ths_q <= REG_RESET;
      wu_dur_q <= REG_RESET;
      inact_q  <= REG_RESET;
      or_ths_q <= REG_RESET;
      route1_q <= REG_RESET;
      route2_q <= REG_RESET;
      for (int i = 0; i < 3; i++) begin
        ofs_q[i] <= REG_RESET;
      end
    end else if (CE_IN && WR_IN) begin
      case (ADDR_IN)
        A_FUNC_EN:  fen_q    <= WDATA_IN;
        A_TAP_CONFIG0_REG: tap_q    <= WDATA_IN;
        A_CONTROL9_REG:    control9_reg_q  <= WDATA_IN;
        A_WU_THS:   wu_ths_q <= WDATA_IN;
        A_WU_DUR:   wu_dur_q <= WDATA_IN;
        A_INACT:    inact_q  <= WDATA_IN;
        A_OR_THS:   or_ths_q <= WDATA_IN;
        A_ROUTE1:   route1_q <= WDATA_IN;
        A_ROUTE2:   route2_q <= WDATA_IN;
        A_X_OFS:    ofs_q[0] <= WDATA_IN;
        A_Y_OFS:    ofs_q[1] <= WDATA_IN;
        A_Z_OFS:    ofs_q[2] <= WDATA_IN;
        default: ;
      endcase
    end
  end

  // Configuration fields
  wire       int_en   = fen_q[B_INT_EN];
  wire       latch_irq_mode      = tap_q[B_LIR];
  wire       fps      = tap_q[B_FPS];
  wire       lp6d     = tap_q[B_LP6D];
  wire       ofs_on   = wu_ths_q[B_OFS_ON_WU];
  wire [1:0] wu_dur   = wu_dur_q[B_DUR_HI:B_DUR_LO];
  wire       four_en  = or_ths_q[B_FOUR_EN];
  wire       stb      = CE_IN && SAMPLE_STB_IN;
  wire       settle_m = control9_reg_q[B_FAST_SET] && tap_q[B_SET_MASK] && SETTLING_IN;

  wire [13:0] wu_thr_raw = wu_ths_q[B_THS_HI:0] * wu_weight(inact_q[B_RES_HI:B_RES_LO]);
  wire [EW-1:0] wu_thr   = EW'(wu_thr_raw);
  wire [EW-1:0] or_thr   = EW'(or_ths(or_ths_q[B_OTH_HI:B_OTH_LO]));

  logic signed [DW-1:0] acc [3];
  logic signed [DW-1:0] hpf [3];
  logic signed [DW-1:0] lp2 [3];
  assign acc = '{ACC_X_IN, ACC_Y_IN, ACC_Z_IN};
  assign hpf = '{HPF_X_IN, HPF_Y_IN, HPF_Z_IN};
  assign lp2 = '{SECOND_LOWPASS_FILTER_X_IN, SECOND_LOWPASS_FILTER_Y_IN, SECOND_LOWPASS_FILTER_Z_IN};

  wire [2:0] over, hi, lo;

  genvar a;
  generate
    for (a = 0; a < 3; a++) begin : g_axis
      logic signed [DW-1:0] prev_q;
      wire signed [EW-1:0] diff  = EW'(acc[a]) - EW'(prev_q);
      wire signed [EW-1:0] slope = diff >>> 1;
      wire signed [EW-1:0] ofs   = EW'($signed(ofs_q[a])) <<< OFS_SHIFT;
      wire signed [EW-1:0] wd    = !fps ? slope :
                                   ofs_on ? EW'(acc[a]) - ofs :
                                   EW'(hpf[a]);
      wire [EW-1:0] wmag = wd[EW-1] ? EW'(-wd) : EW'(wd);
      wire signed [EW-1:0] od   = EW'(lp6d ? lp2[a] : acc[a]);
      wire [EW-1:0] omag = od[EW-1] ? EW'(-od) : EW'(od);
      assign over[a] = wmag > wu_thr;
      assign hi[a]   = !od[EW-1] && (omag > or_thr);
      assign lo[a]   = od[EW-1] && (omag > or_thr);

      // Previous sample is zero on the first sample after enabling
      always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
          prev_q <= '0;
        end else if (CE_IN && !int_en) begin
          prev_q <= '0;
        end else if (stb) begin
          prev_q <= acc[a];
        end
      end
    end
  endgenerate

  // Wake-up
  logic [1:0] dur_cnt_q;
  logic       wu_live_q, wu_lat_q;
  logic [2:0] wu_ax_live_q, wu_ax_lat_q;

  wire wu_route  = route1_q[B_RT_WU] || route2_q[B_RT_WU];
  wire wu_latch  = latch_irq_mode && wu_route;
  wire over_any  = int_en && !settle_m && (|over);
  wire wu_now    = over_any && (dur_cnt_q >= wu_dur);
  wire wu_set    = stb && wu_now;
  wire wu_clr    = CE_IN && (rd_wu || rd_all);
  wire wu_flag   = wu_latch ? wu_lat_q : wu_live_q;
  wire [2:0] wu_axes = wu_latch ? wu_ax_lat_q : wu_ax_live_q;

  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      dur_cnt_q    <= '0;
      wu_live_q    <= 1'b0;
      wu_ax_live_q <= '0;
    end else if (stb) begin
      dur_cnt_q    <= !over_any ? 2'h0 :
                      (dur_cnt_q == DUR_MAX) ? DUR_MAX : dur_cnt_q + 2'h1;
      wu_live_q    <= wu_now;
      wu_ax_live_q <= over & {3{wu_now}};
    end
  end

  // Set wins over a clearing read in the same cycle
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      wu_lat_q    <= 1'b0;
      wu_ax_lat_q <= '0;
    end else if (CE_IN) begin
      wu_lat_q <= wu_latch && (wu_set || (wu_lat_q && !wu_clr));
      if (!wu_latch) begin
        wu_ax_lat_q <= '0;
      end else if (wu_set && (!wu_lat_q || wu_clr)) begin
        wu_ax_lat_q <= over;
      end else if (wu_clr) begin
        wu_ax_lat_q <= '0;
      end
    end
  end

  // Orientation
  logic [5:0] cand_prev_q, last_q, pos_q;
  logic       or_live_q, or_lat_q;

  wire [2:0] use_ax = {!four_en, 2'b11};
  wire [2:0] hi_m   = hi & use_ax;
  wire [2:0] lo_m   = lo & use_ax;
  wire [2:0] ax_hit = hi_m | lo_m;
  wire       one_ax = (ax_hit == 3'b001) || (ax_hit == 3'b010) || (ax_hit == 3'b100);
  wire [5:0] cand   = {hi_m[2], lo_m[2], hi_m[1], lo_m[1], hi_m[0], lo_m[0]};
  wire       or_now = int_en && !settle_m && one_ax && (cand == cand_prev_q)
                      && (cand != last_q);
  wire or_route = route1_q[B_RT_OR] || route2_q[B_RT_OR];
  wire or_latch = latch_irq_mode && or_route;
  wire or_set   = stb && or_now;
  wire or_clr   = CE_IN && (rd_or || rd_all);
  wire or_flag  = or_latch ? or_lat_q : or_live_q;

  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cand_prev_q <= '0;
      last_q      <= '0;
      pos_q       <= '0;
      or_live_q   <= 1'b0;
    end else if (stb) begin
      cand_prev_q <= one_ax ? cand : 6'h00;
      pos_q       <= cand;
      or_live_q   <= or_now;
      if (or_now) begin
        last_q <= cand;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      or_lat_q <= 1'b0;
    end else if (CE_IN) begin
      or_lat_q <= or_latch && (or_set || (or_lat_q && !or_clr));
    end
  end

  // Strobes that pass while the unlatched orientation pulse stands
  logic [1:0] or_pulse_stb_q;
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      or_pulse_stb_q <= 2'h0;
    end else if (CE_IN) begin
      if (!or_live_q) begin
        or_pulse_stb_q <= 2'h0;
      end else if (stb && !or_pulse_stb_q[1]) begin
        or_pulse_stb_q <= or_pulse_stb_q + 2'h1;
      end
    end
  end

  // Pins and read data
  wire pin1_d = int_en && ((route1_q[B_RT_WU] && wu_flag) ||
                           (route1_q[B_RT_OR] && or_flag));
  wire pin2_d = int_en && ((route2_q[B_RT_WU] && wu_flag) ||
                           (route2_q[B_RT_OR] && or_flag));

  // Source layouts: wake {0,0,0,0,flag,x,y,z}, orient {0,flag,zh,zl,yh,yl,xh,xl}
  wire [7:0] wu_src  = {4'h0, wu_flag, wu_axes[0], wu_axes[1], wu_axes[2]};
  wire [7:0] or_src  = {1'b0, or_flag, pos_q};
  wire [7:0] all_src = {3'h0, or_flag, 2'h0, wu_flag, 1'b0};
  wire [7:0] rd_mux  =
    (ADDR_IN == A_FUNC_EN)  ? fen_q    : (ADDR_IN == A_TAP_CONFIG0_REG) ? tap_q    :
    (ADDR_IN == A_CONTROL9_REG)    ? control9_reg_q  : (ADDR_IN == A_WU_THS)   ? wu_ths_q :
    (ADDR_IN == A_WU_DUR)   ? wu_dur_q : (ADDR_IN == A_INACT)    ? inact_q  :
    (ADDR_IN == A_OR_THS)   ? or_ths_q : (ADDR_IN == A_ROUTE1)   ? route1_q :
    (ADDR_IN == A_ROUTE2)   ? route2_q : (ADDR_IN == A_X_OFS)    ? ofs_q[0] :
    (ADDR_IN == A_Y_OFS)    ? ofs_q[1] : (ADDR_IN == A_Z_OFS)    ? ofs_q[2] :
    rd_wu ? wu_src : rd_or ? or_src : rd_all ? all_src : 8'h00;

  logic pin1_q, pin2_q;
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      pin1_q  <= 1'b0;
      pin2_q  <= 1'b0;
      rdata_q <= 8'h00;
    end else if (CE_IN) begin
      pin1_q  <= pin1_d;
      pin2_q  <= pin2_d;
      rdata_q <= RD_IN ? rd_mux : 8'h00;
    end
  end

  assign INTERRUPT_PIN_ONE_OUT = pin1_q;
  assign INTERRUPT_PIN_TWO_OUT = pin2_q;
  assign RDATA_OUT             = rdata_q;

  // Checks
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!NRST_IN);

  sequence s_or_fire;
    stb && or_now;
  endsequence
  sequence s_or_next_quiet;
    stb && !or_now;
  endsequence

  a_strict_thresh: assert property (stb && int_en && !(|over) |=> !wu_live_q)
    else $error("wake-up raised without a sample above threshold");
  a_dur_zero_fire: assert property (stb && over_any && wu_dur == 2'h0 |=> wu_live_q)
    else $error("zero duration did not raise wake-up");
  a_pin_gated_off: assert property (CE_IN && !int_en |=> !pin1_q && !pin2_q)
    else $error("pin driven with interrupts disabled");
  a_axes_latched: assert property (CE_IN && wu_lat_q && wu_latch && !wu_clr |=> $stable(wu_ax_lat_q))
    else $error("latched wake-up axis flags changed");
  a_wu_latch_hold: assert property (CE_IN && wu_lat_q && wu_latch && !wu_clr |=> wu_lat_q)
    else $error("latched wake-up dropped without a read");
  a_or_pulse_len: assert property (s_or_next_quiet |=> !or_live_q)
    else $error("orientation pulse longer than one sample");
  a_or_pulse_cnt: assert property (or_pulse_stb_q <= 2'h1)
    else $error("orientation pulse spans more than one strobe");
  a_or_two_match: assert property (s_or_fire |-> one_ax && cand == cand_prev_q)
    else $error("orientation fired without two matching samples");
  a_or_no_repeat: assert property (stb && cand == last_q |-> !or_now)
    else $error("orientation refired for unchanged position");
  a_or_read_clear: assert property (CE_IN && or_lat_q && or_clr && !or_set |=> !or_lat_q)
    else $error("orientation latch survived a source read");
  a_four_no_z: assert property (stb && four_en |=> pos_q[5:4] == 2'b00)
    else $error("Z position flag set in four-orientation mode");
  a_settle_mask: assert property (stb && settle_m |=> !wu_live_q && !or_live_q)
    else $error("event triggered during masked settling");
  a_unlatched_drop: assert property (stb && !over_any |=> !wu_live_q)
    else $error("live wake-up stayed with data below threshold");
  a_strobe_only: assert property (!stb |=> $stable(dur_cnt_q) && $stable(wu_live_q) && $stable(or_live_q))
    else $error("event state moved without a sample strobe");
  a_pos_current: assert property (stb |=> pos_q == $past(cand))
    else $error("position flags do not follow the current sample");
  a_latch_unrouted: assert property (CE_IN && !wu_latch |=> !wu_lat_q)
    else $error("wake-up latched while not routed or latch off");
  a_hi_lo_excl: assert property (stb |-> (hi & lo) == 3'b000)
    else $error("axis flagged high and low at once");
  a_pin_or_wake: assert property (CE_IN && int_en && route1_q[B_RT_WU] && wu_flag |=> pin1_q)
    else $error("pin one missed a routed wake-up");
  a_pin_or_orient: assert property (CE_IN && int_en && route2_q[B_RT_OR] && or_flag |=> pin2_q)
    else $error("pin two missed a routed orientation event");

endmodule : wod_detect

`default_nettype wire

// ==== wod_detect_tb_top.sv ====
// Self-checking bench for wod_detect, compared with a behavioural model.
// Assumes the wod_pkg register map; clock enable held high, one clock domain.
`timescale 1ns/1ns
`default_nettype none
module wod_detect_tb_top;
  import wod_pkg::*;
  logic               clk, nrst, wr, rd, stb, settling, pin1, pin2;
  logic        [7:0]  addr, wdata, rdata;
  logic signed [15:0] acc [3];
  logic signed [15:0] hpf [3];
  logic signed [15:0] lpf [3];
  int                 n_mismatch, checks_done, cnt;
  int                 va [3];
  int                 vh [3];
  int                 vl [3];
  int                 prev [3];
  int                 wt [8] = '{11, 31, 62, 125, 250, 250, 250, 250};
  int                 ots [4] = '{1792, 1536, 1000, 688};
  int                 tv [5] = '{125, 126, -125, -126, 0};
  logic        [7:0]  rf [12];
  bit                 wu_live, wu_lat, or_live, or_lat;
  bit          [2:0]  wu_ax, lat_ax;
  bit          [5:0]  or_prev, or_rep, or_flags;

  wod_detect #(.DW(16)) wod_detect_inst (
    .CLK_SYS_IN(clk), .NRST_IN(nrst), .CE_IN(1'b1), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .SAMPLE_STB_IN(stb), .SETTLING_IN(settling),
    .ACC_X_IN(acc[0]), .ACC_Y_IN(acc[1]), .ACC_Z_IN(acc[2]),
    .HPF_X_IN(hpf[0]), .HPF_Y_IN(hpf[1]), .HPF_Z_IN(hpf[2]),
    .SECOND_LOWPASS_FILTER_X_IN(lpf[0]), .SECOND_LOWPASS_FILTER_Y_IN(lpf[1]), .SECOND_LOWPASS_FILTER_Z_IN(lpf[2]),
    .INTERRUPT_PIN_ONE_OUT(pin1), .INTERRUPT_PIN_TWO_OUT(pin2));

  function automatic bit latched(input int b);
    return rf[A_TAP_CONFIG0_REG][B_LIR] & (rf[A_ROUTE1][b] | rf[A_ROUTE2][b]);
  endfunction : latched

  function automatic logic [7:0] expect_rd(input logic [7:0] a);
    bit w, o;
    w = latched(B_RT_WU) ? wu_lat : wu_live;
    o = latched(B_RT_OR) ? or_lat : or_live;
    if (a == A_WU_SRC) return {4'h0, w, (latched(B_RT_WU) ? (wu_lat ? lat_ax : 3'h0) : wu_ax)};
    if (a == A_OR_SRC) return {1'b0, o, or_flags};
    if (a == A_ALL_SRC) return {3'h0, o, 2'h0, w, 1'b0};
    return (a < A_WU_SRC) ? rf[a[3:0]] : 8'h00;
  endfunction : expect_rd

  function automatic logic [1:0] exp_pins();
    logic [7:0] s;
    s = expect_rd(A_ALL_SRC) & {8{rf[A_FUNC_EN][B_INT_EN]}};
    return {rf[A_ROUTE2][B_RT_WU] & s[1] | rf[A_ROUTE2][B_RT_OR] & s[4],
            rf[A_ROUTE1][B_RT_WU] & s[1] | rf[A_ROUTE1][B_RT_OR] & s[4]};
  endfunction : exp_pins

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    if (a < A_WU_SRC) rf[a[3:0]] = d;
    if (!latched(B_RT_WU)) wu_lat = 0;
    if (!latched(B_RT_OR)) or_lat = 0;
    if (!rf[A_FUNC_EN][B_INT_EN]) prev = '{0, 0, 0};
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    logic [7:0] e;
    e = expect_rd(a);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    if (a == A_WU_SRC || a == A_ALL_SRC) wu_lat = 0;
    if (a == A_OR_SRC || a == A_ALL_SRC) or_lat = 0;
    @(negedge clk);
    chk(rdata, e);
    @(posedge clk);
  endtask : rd_reg

  // One strobe; the model steps once, then both pins are compared
  task automatic sample();
    int v, o, thr, oth;
    bit en;
    bit [2:0] exc;
    bit [5:0] c;
    for (int i = 0; i < 3; i++) begin
      acc[i] <= 16'(va[i]);
      hpf[i] <= 16'(vh[i]);
      lpf[i] <= 16'(vl[i]);
    end
    stb <= 1'b1;
    @(posedge clk);
    stb <= 1'b0;
    thr = rf[A_WU_THS][5:0] * wt[rf[A_INACT][6:4]];
    oth = ots[rf[A_OR_THS][6:5]];
    en = rf[A_FUNC_EN][B_INT_EN] & !(rf[A_CONTROL9_REG][B_FAST_SET] & rf[A_TAP_CONFIG0_REG][B_SET_MASK] & settling);
    for (int i = 0; i < 3; i++) begin
      if (!rf[A_TAP_CONFIG0_REG][B_FPS]) v = (va[i] - prev[i]) >>> 1;
      else if (rf[A_WU_THS][B_OFS_ON_WU]) v = va[i] - 8 * int'($signed(rf[A_X_OFS + i]));
      else v = vh[i];
      exc[2 - i] = en && ((v < 0 ? -v : v) > thr);
      o = rf[A_TAP_CONFIG0_REG][B_LP6D] ? vl[i] : va[i];
      c[2 * i + 1] = o > oth;
      c[2 * i] = o < -oth;
    end
    if (rf[A_OR_THS][B_FOUR_EN]) c[5:4] = 2'b00;
    or_flags = c;
    or_live = en && $onehot(c) && c == or_prev && c != or_rep;
    or_prev = c;
    if (or_live) or_rep = c;
    if (or_live && latched(B_RT_OR)) or_lat = 1;
    wu_live = (|exc) && cnt >= int'(rf[A_WU_DUR][6:5]);
    cnt = (|exc) ? cnt + 1 : 0;
    wu_ax = wu_live ? exc : 3'b000;
    if (wu_live && latched(B_RT_WU) && !wu_lat) lat_ax = exc;
    if (wu_live && latched(B_RT_WU)) wu_lat = 1;
    if (rf[A_FUNC_EN][B_INT_EN]) prev = va;
    else prev = '{0, 0, 0};
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({6'h0, pin2, pin1}, {6'h0, exp_pins()});
    @(posedge clk);
  endtask : sample

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (6000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    nrst = 1'b0; wr = 1'b0; rd = 1'b0; stb = 1'b0; settling = 1'b0; addr = 8'h00; wdata = 8'h00;
    foreach (acc[i]) begin acc[i] = 0; hpf[i] = 0; lpf[i] = 0; end
    foreach (rf[i]) rf[i] = REG_RESET;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    void'($urandom(64808));
    rd_reg(A_FUNC_EN);
    rd_reg(8'h3F);
    wr_reg(A_WU_SRC, 8'hFF);
    rd_reg(A_WU_SRC);
    wr_reg(A_INACT, 8'h34);
    wr_reg(A_WU_THS, 8'h01);
    wr_reg(A_TAP_CONFIG0_REG, 8'h10);
    wr_reg(A_ROUTE1, 8'h20);
    vh = '{0, 126, 0};
    sample();
    wr_reg(A_FUNC_EN, 8'h80);
    foreach (tv[i]) begin
      vh = '{0, tv[i], 0};
      sample();
    end
    wr_reg(A_WU_DUR, 8'h40);
    for (int i = 0; i < 5; i++) begin
      vh = '{0, 0, i < 4 ? 200 : 0};
      sample();
    end
    for (int i = 0; i < 40; i++) begin
      if (i % 8 == 0) begin
        wr_reg(A_WU_DUR, 8'($urandom_range(3)) << 5);
        wr_reg(A_INACT, 8'($urandom_range(7)) << 4);
        wr_reg(A_WU_THS, 8'($urandom_range(3)));
      end
      foreach (vh[j]) vh[j] = int'($urandom_range(800)) - 400;
      sample();
    end
    wr_reg(A_WU_DUR, 8'h00);
    wr_reg(A_INACT, 8'h34);
    wr_reg(A_WU_THS, 8'h01);
    wr_reg(A_TAP_CONFIG0_REG, 8'h11);
    vh = '{0, -130, 0};
    sample();
    vh = '{130, 0, 0};
    sample();
    vh = '{0, 0, 0};
    sample();
    rd_reg(A_WU_SRC);
    sample();
    vh = '{0, 0, 130};
    sample();
    rd_reg(A_ALL_SRC);
    vh = '{0, 0, 0};
    sample();
    wr_reg(A_ROUTE1, 8'h00);
    vh = '{130, 0, 0};
    sample();
    vh = '{0, 0, 0};
    sample();
    rd_reg(A_WU_SRC);
    wr_reg(A_ROUTE2, 8'h20);
    wr_reg(A_TAP_CONFIG0_REG, 8'h10);
    vh = '{0, 130, 0};
    sample();
    vh = '{0, 0, 0};
    wr_reg(A_ROUTE1, 8'h20);
    wr_reg(A_X_OFS, 8'h10);
    wr_reg(A_WU_THS, 8'h41);
    va = '{254, 0, 0};
    sample();
    va = '{253, 0, 0};
    sample();
    va = '{2, 0, 0};
    sample();
    wr_reg(A_WU_THS, 8'h01);
    va = '{0, 0, 0};
    sample();
    wr_reg(A_FUNC_EN, 8'h00);
    wr_reg(A_TAP_CONFIG0_REG, 8'h00);
    wr_reg(A_ROUTE2, 8'h00);
    wr_reg(A_FUNC_EN, 8'h80);
    va = '{0, 0, 2000};
    repeat (2) sample();
    wr_reg(A_CONTROL9_REG, 8'h20);
    wr_reg(A_TAP_CONFIG0_REG, 8'h30);
    settling <= 1'b1;
    vh = '{0, 200, 0};
    sample();
    settling <= 1'b0;
    sample();
    vh = '{0, 0, 0};
    wr_reg(A_ROUTE2, 8'h04);
    wr_reg(A_OR_THS, 8'h40);
    wr_reg(A_TAP_CONFIG0_REG, 8'h10);
    repeat (2) sample();
    va = '{0, 1100, 0};
    repeat (3) sample();
    rd_reg(A_OR_SRC);
    wr_reg(A_TAP_CONFIG0_REG, 8'h50);
    vl = '{-1100, 0, 0};
    repeat (2) sample();
    rd_reg(A_OR_SRC);
    wr_reg(A_TAP_CONFIG0_REG, 8'h51);
    vl = '{0, 0, -1100};
    repeat (3) sample();
    rd_reg(A_OR_SRC);
    sample();
    wr_reg(A_ROUTE1, 8'h24);
    wr_reg(A_TAP_CONFIG0_REG, 8'h50);
    vl = '{0, 0, 1100};
    vh = '{0, 0, 200};
    sample();
    vh = '{0, 0, 0};
    sample();
    wr_reg(A_OR_THS, 8'hC0);
    vl = '{0, 0, -1100};
    repeat (2) sample();
    rd_reg(A_OR_SRC);
    vl = '{1100, 0, 0};
    repeat (2) sample();
    give_verdict();
  end
endmodule : wod_detect_tb_top
`default_nettype wire
